// [logic/cld_params.svh]
// Register offsets, field positions, reset values and cycle counts of the decode core
`ifndef CLD_PARAMS_SVH
`define CLD_PARAMS_SVH

`define CLD_OFF_CTRL 12'h000
`define CLD_OFF_STATUS 12'h004
`define CLD_OFF_INSTR 12'h008
`define CLD_OFF_ACC 12'h00c
`define CLD_OFF_PC 12'h010
`define CLD_OFF_FLAGS 12'h014
`define CLD_OFF_INDEX 12'h018
`define CLD_OFF_EXTRA 12'h01c
`define CLD_OFF_GREG_BASE 12'h040
`define CLD_OFF_GREG_LAST 12'h05c
`define CLD_OFF_MEM_BASE 12'h400
`define CLD_OFF_MEM_LAST 12'h7fc

`define CLD_CTRL_START 0
`define CLD_STAT_BUSY 0
`define CLD_STAT_TAKEN 1
`define CLD_STAT_ILLEGAL 2
`define CLD_STAT_CYC_LSB 4

`define CLD_FLAG_N 3
`define CLD_FLAG_Z 2
`define CLD_FLAG_V 1
`define CLD_FLAG_C 0

`define CLD_RST_ACC 16'h0000
`define CLD_RST_PC 16'h0000
`define CLD_RST_FLAGS 4'h0
`define CLD_RST_PTR 16'h0000
`define CLD_RST_GREG 8'h00

`define CLD_CYC_IMM 3'h2
`define CLD_CYC_SHORT 3'h3
`define CLD_CYC_INDEXED 3'h4
`define CLD_CYC_BITBR 3'h5
`define CLD_CYC_ILLEGAL 3'h1

`define CLD_LEN_ONE 2'h1
`define CLD_LEN_TWO 2'h2
`define CLD_LEN_THREE 2'h3

`endif

// [logic/cld_pkg.sv]
// Types shared by the decode core and its execute unit
package cld_pkg;

	typedef enum logic [1:0] {
		CLD_IDLE = 2'h0,
		CLD_EXEC = 2'h1,
		CLD_COMMIT = 2'h3
	} cld_state_e;

	typedef enum logic [2:0] {
		CLD_CL_AND = 3'h0,
		CLD_CL_OR = 3'h1,
		CLD_CL_BRANCH = 3'h2,
		CLD_CL_BITBR = 3'h3,
		CLD_CL_WORD_EXCHANGE = 3'h4,
		CLD_CL_BAD = 3'h5
	} cld_class_e;

endpackage

// [logic/cld_exec.sv]
// Combinational decode and result of one instruction
`timescale 1ns/1ps
`include "cld_params.svh"

module cld_exec (
	// Latched instruction
	input wire logic [7:0] op_i,
	input wire logic [7:0] b1_i,
	input wire logic [7:0] b2_i,
	// Architectural state
	input wire logic [15:0] acc_i,
	input wire logic [15:0] pc_i,
	input wire logic [15:0] index_pointer_i,
	input wire logic [15:0] extra_pointer_i,
	input wire logic [3:0] flags_i,
	input wire logic [7:0] greg_i,
	input wire logic [7:0] mem_data_i,
	// Operand selects
	output logic [2:0] greg_sel_o,
	output logic [15:0] mem_addr_o,
	// Results
	output logic [15:0] acc_o,
	output logic [15:0] pc_o,
	output logic [3:0] flags_o,
	output logic [2:0] cycles_o,
	output logic taken_o,
	output logic illegal_o
);

	function automatic logic [15:0] rel_target(input logic [15:0] seq, input logic [7:0] rel);
		rel_target = seq + {{8{rel[7]}}, rel};
	endfunction

	function automatic logic [3:0] logic_flags(input logic [7:0] res, input logic c);
		logic_flags = {res[7], res == 8'h00, 1'b0, c};
	endfunction

	cld_pkg::cld_class_e cls;
	logic [1:0] len;
	logic use_imm;
	logic use_reg;
	logic [7:0] operand;
	logic [7:0] res;
	logic cond;
	logic bit_val;
	logic [15:0] seq_pc;

	always_comb begin
		cls = cld_pkg::CLD_CL_BAD;
		cycles_o = `CLD_CYC_ILLEGAL;
		len = `CLD_LEN_ONE;
		use_imm = 1'b0;
		use_reg = 1'b0;
		mem_addr_o = 16'h0000;
		casez (op_i)
			8'h67, 8'h77: begin
				cls = op_i[4] ? cld_pkg::CLD_CL_OR : cld_pkg::CLD_CL_AND;
				mem_addr_o = extra_pointer_i; // [RULE1] [RULE6]
				cycles_o = `CLD_CYC_SHORT;
			end
			8'h66, 8'h76: begin
				cls = op_i[4] ? cld_pkg::CLD_CL_OR : cld_pkg::CLD_CL_AND;
				mem_addr_o = index_pointer_i + {8'h00, b1_i}; // [RULE2] [RULE7]
				cycles_o = `CLD_CYC_INDEXED;
				len = `CLD_LEN_TWO;
			end
			8'b0110_1???, 8'b0111_1???: begin
				cls = op_i[4] ? cld_pkg::CLD_CL_OR : cld_pkg::CLD_CL_AND;
				use_reg = 1'b1; // [RULE3] [RULE8]
				cycles_o = `CLD_CYC_SHORT;
			end
			8'h74: begin
				cls = cld_pkg::CLD_CL_OR;
				use_imm = 1'b1; // [RULE4]
				cycles_o = `CLD_CYC_IMM;
				len = `CLD_LEN_TWO;
			end
			8'h75: begin
				cls = cld_pkg::CLD_CL_OR;
				mem_addr_o = {8'h00, b1_i}; // [RULE5]
				cycles_o = `CLD_CYC_SHORT;
				len = `CLD_LEN_TWO;
			end
			8'b1111_1???: begin
				cls = cld_pkg::CLD_CL_BRANCH;
				cycles_o = `CLD_CYC_SHORT;
				len = `CLD_LEN_TWO;
			end
			8'b1011_????: begin
				cls = cld_pkg::CLD_CL_BITBR;
				mem_addr_o = {8'h00, b1_i}; // [RULE14]
				cycles_o = `CLD_CYC_BITBR;
				len = `CLD_LEN_THREE;
			end
			8'hf4: begin
				cls = cld_pkg::CLD_CL_WORD_EXCHANGE;
				cycles_o = `CLD_CYC_SHORT; // [RULE15]
			end
			default: begin
				cls = cld_pkg::CLD_CL_BAD;
			end
		endcase
	end

	assign greg_sel_o = op_i[2:0];

	always_comb begin
		operand = use_imm ? b1_i : (use_reg ? greg_i : mem_data_i);
		res = (cls == cld_pkg::CLD_CL_OR) ? (acc_i[7:0] | operand) : (acc_i[7:0] & operand);
		bit_val = mem_data_i[op_i[2:0]];
		seq_pc = pc_i + {14'h0000, len}; // [RULE16]
		unique case (op_i[2:0])
			3'h0: cond = ~flags_i[`CLD_FLAG_C]; // [RULE11]
			3'h1: cond = flags_i[`CLD_FLAG_C]; // [RULE11]
			3'h2: cond = ~flags_i[`CLD_FLAG_N]; // [RULE12]
			3'h3: cond = flags_i[`CLD_FLAG_N]; // [RULE12]
			3'h4: cond = ~flags_i[`CLD_FLAG_Z]; // [RULE10]
			3'h5: cond = flags_i[`CLD_FLAG_Z]; // [RULE9]
			3'h6: cond = ~(flags_i[`CLD_FLAG_V] ^ flags_i[`CLD_FLAG_N]); // [RULE13]
			3'h7: cond = flags_i[`CLD_FLAG_V] ^ flags_i[`CLD_FLAG_N]; // [RULE13]
		endcase
	end

	always_comb begin
		acc_o = acc_i;
		pc_o = seq_pc;
		flags_o = flags_i;
		taken_o = 1'b0;
		illegal_o = 1'b0;
		unique case (cls)
			cld_pkg::CLD_CL_AND, cld_pkg::CLD_CL_OR: begin
				// High byte kept so word results stay intact
				acc_o = {acc_i[15:8], res}; // [RULE17]
				flags_o = logic_flags(res, flags_i[`CLD_FLAG_C]); // [RULE1] [RULE4]
			end
			cld_pkg::CLD_CL_BRANCH: begin
				taken_o = cond;
				pc_o = cond ? rel_target(seq_pc, b1_i) : seq_pc; // [RULE9] [RULE16]
			end
			cld_pkg::CLD_CL_BITBR: begin
				taken_o = bit_val == op_i[3]; // [RULE14]
				pc_o = taken_o ? rel_target(seq_pc, b2_i) : seq_pc; // [RULE14]
				flags_o[`CLD_FLAG_Z] = ~bit_val; // [RULE14]
			end
			cld_pkg::CLD_CL_WORD_EXCHANGE: begin
				pc_o = acc_i; // [RULE15]
				acc_o = pc_i + 16'h0001; // [RULE15]
			end
			cld_pkg::CLD_CL_BAD: begin
				pc_o = pc_i;
				illegal_o = 1'b1;
			end
		endcase
	end

endmodule

// [logic/cld_core.sv]
// Decode core for logic, branch and word exchange instructions, reached over Avalon-MM
//
// Overview of operation
// [RULE1] AND low accumulator with extra-pointer byte
// [RULE2] AND with indexed byte, four cycles
// [RULE3] AND with general register, three cycles
// [RULE4] OR with immediate byte, two cycles
// [RULE5] OR with direct-addressed byte, three cycles
// [RULE6] OR with extra-pointer byte, three cycles
// [RULE7] OR with indexed byte, four cycles
// [RULE8] OR with general register, three cycles
// [RULE9] Branch on zero set
// [RULE10] Branch on zero clear
// [RULE11] Branch on carry set or clear
// [RULE12] Branch on negative set or clear
// [RULE13] Branch on signed less or greater-equal
// [RULE14] Bit test branch, five cycles, sets zero
// [RULE15] Exchange accumulator word with program counter; the code loads the accumulator with the program counter plus one
// [RULE16] Displacement is signed, from next instruction
// [RULE17] Logic forms touch only the low byte
`timescale 1ns/1ps
`include "cld_params.svh"

module cld_core (
	// Clock, reset, enable
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	// Avalon-MM slave
	input wire logic [11:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Status
	output logic busy_o
);

	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		for (int i = 0; i < 4; i++) begin
			be_merge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	function automatic logic in_range(input logic [11:0] a, input logic [11:0] lo, input logic [11:0] hi);
		in_range = (a >= lo) && (a <= hi) && (a[1:0] == 2'h0);
	endfunction

	cld_pkg::cld_state_e state_reg;
	logic [2:0] cnt_reg;
	logic wait_reg;
	logic [31:0] rdata_reg;
	logic [7:0] op_reg;
	logic [7:0] b1_reg;
	logic [7:0] b2_reg;
	logic [15:0] acc_reg;
	logic [15:0] pc_reg;
	logic [3:0] flags_reg;
	logic [15:0] index_pointer_reg;
	logic [15:0] extra_pointer_reg;
	logic [7:0] general_register_i_reg [8];
	logic [7:0] data_mem [256];
	logic taken_reg;
	logic illegal_reg;
	logic [2:0] last_cyc_reg;

	logic [2:0] greg_sel;
	logic [15:0] mem_addr;
	logic [15:0] acc_next;
	logic [15:0] pc_next;
	logic [3:0] flags_next;
	logic [2:0] cycles;
	logic taken;
	logic illegal;

	logic accept;
	logic wr_ok;
	logic [31:0] rd_mux;
	logic [31:0] old_word;
	logic [31:0] wr_word;
	logic start;
	logic commit;
	logic wr_acc;
	logic wr_pc;
	logic wr_flags;
	logic wr_instr;
	logic wr_index;
	logic wr_extra;
	logic wr_greg;
	logic wr_mem;

	cld_exec u_exec (
		.op_i(op_reg),
		.b1_i(b1_reg),
		.b2_i(b2_reg),
		.acc_i(acc_reg),
		.pc_i(pc_reg),
		.index_pointer_i(index_pointer_reg),
		.extra_pointer_i(extra_pointer_reg),
		.flags_i(flags_reg),
		.greg_i(general_register_i_reg[greg_sel]),
		.mem_data_i(data_mem[mem_addr[7:0]]),
		.greg_sel_o(greg_sel),
		.mem_addr_o(mem_addr),
		.acc_o(acc_next),
		.pc_o(pc_next),
		.flags_o(flags_next),
		.cycles_o(cycles),
		.taken_o(taken),
		.illegal_o(illegal)
	);

	// Accept edge is the one where the master sees waitrequest low
	assign accept = (avs_read_i | avs_write_i) & ~wait_reg;
	// Architectural state is frozen while an instruction runs
	assign wr_ok = accept & avs_write_i & (state_reg == cld_pkg::CLD_IDLE);
	assign start = wr_ok & (avs_address_i == `CLD_OFF_CTRL) & avs_byteenable_i[0]
		& avs_writedata_i[`CLD_CTRL_START];
	assign commit = state_reg == cld_pkg::CLD_COMMIT;

	// Write strobes, already gated by accept and idle
	assign wr_acc = wr_ok & (avs_address_i == `CLD_OFF_ACC);
	assign wr_pc = wr_ok & (avs_address_i == `CLD_OFF_PC);
	assign wr_flags = wr_ok & (avs_address_i == `CLD_OFF_FLAGS);
	assign wr_instr = wr_ok & (avs_address_i == `CLD_OFF_INSTR);
	assign wr_index = wr_ok & (avs_address_i == `CLD_OFF_INDEX);
	assign wr_extra = wr_ok & (avs_address_i == `CLD_OFF_EXTRA);
	assign wr_greg = wr_ok & in_range(avs_address_i, `CLD_OFF_GREG_BASE, `CLD_OFF_GREG_LAST);
	assign wr_mem = wr_ok & in_range(avs_address_i, `CLD_OFF_MEM_BASE, `CLD_OFF_MEM_LAST);

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (avs_address_i == `CLD_OFF_STATUS) begin
			rd_mux[`CLD_STAT_BUSY] = state_reg != cld_pkg::CLD_IDLE;
			rd_mux[`CLD_STAT_TAKEN] = taken_reg;
			rd_mux[`CLD_STAT_ILLEGAL] = illegal_reg;
			rd_mux[`CLD_STAT_CYC_LSB +: 3] = last_cyc_reg;
		end else if (avs_address_i == `CLD_OFF_INSTR) begin
			rd_mux = {8'h00, b2_reg, b1_reg, op_reg};
		end else if (avs_address_i == `CLD_OFF_ACC) begin
			rd_mux = {16'h0000, acc_reg};
		end else if (avs_address_i == `CLD_OFF_PC) begin
			rd_mux = {16'h0000, pc_reg};
		end else if (avs_address_i == `CLD_OFF_FLAGS) begin
			rd_mux = {28'h0000000, flags_reg};
		end else if (avs_address_i == `CLD_OFF_INDEX) begin
			rd_mux = {16'h0000, index_pointer_reg};
		end else if (avs_address_i == `CLD_OFF_EXTRA) begin
			rd_mux = {16'h0000, extra_pointer_reg};
		end else if (in_range(avs_address_i, `CLD_OFF_GREG_BASE, `CLD_OFF_GREG_LAST)) begin
			rd_mux = {24'h000000, general_register_i_reg[avs_address_i[4:2]]};
		end else if (in_range(avs_address_i, `CLD_OFF_MEM_BASE, `CLD_OFF_MEM_LAST)) begin
			rd_mux = {24'h000000, data_mem[avs_address_i[9:2]]};
		end
	end

	always_comb begin
		old_word = rd_mux;
		wr_word = be_merge(old_word, avs_writedata_i, avs_byteenable_i);
	end

	// Bus handshake: one wait cycle, then a single accept cycle
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wait_reg <= 1'b1;
			rdata_reg <= 32'h0000_0000;
		end else if (ce_i) begin
			if ((avs_read_i | avs_write_i) & wait_reg) begin
				wait_reg <= 1'b0;
				rdata_reg <= avs_read_i ? rd_mux : 32'h0000_0000;
			end else begin
				wait_reg <= 1'b1;
			end
		end
	end

	assign avs_waitrequest_o = wait_reg;
	assign avs_readdata_o = rdata_reg;

	// Sequencer holds each instruction for its documented cycle count
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_reg <= cld_pkg::CLD_IDLE;
			cnt_reg <= 3'h0;
			busy_o <= 1'b0;
		end else if (ce_i) begin
			unique case (state_reg)
				cld_pkg::CLD_IDLE: begin
					if (start) begin
						busy_o <= 1'b1;
						cnt_reg <= cycles - 3'h1;
						state_reg <= (cycles == 3'h1) ? cld_pkg::CLD_COMMIT : cld_pkg::CLD_EXEC;
					end
				end
				cld_pkg::CLD_EXEC: begin
					cnt_reg <= cnt_reg - 3'h1;
					if (cnt_reg == 3'h1) begin
						state_reg <= cld_pkg::CLD_COMMIT; // [RULE2] [RULE14]
					end
				end
				cld_pkg::CLD_COMMIT: begin
					busy_o <= 1'b0;
					state_reg <= cld_pkg::CLD_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			acc_reg <= `CLD_RST_ACC;
		end else if (ce_i) begin
			if (commit) begin
				acc_reg <= acc_next; // [RULE15] [RULE17]
			end else if (wr_acc) begin
				acc_reg <= wr_word[15:0];
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pc_reg <= `CLD_RST_PC;
		end else if (ce_i) begin
			if (commit) begin
				pc_reg <= pc_next; // [RULE9] [RULE16]
			end else if (wr_pc) begin
				pc_reg <= wr_word[15:0];
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			flags_reg <= `CLD_RST_FLAGS;
		end else if (ce_i) begin
			if (commit) begin
				flags_reg <= flags_next; // [RULE1] [RULE14]
			end else if (wr_flags) begin
				flags_reg <= wr_word[3:0];
			end
		end
	end

	// Status taken, illegal and cycle fields describe the last committed instruction only; busy is live
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			taken_reg <= 1'b0;
			illegal_reg <= 1'b0;
			last_cyc_reg <= 3'h0;
		end else if (ce_i && commit) begin
			taken_reg <= taken;
			illegal_reg <= illegal;
			last_cyc_reg <= cycles;
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			op_reg <= 8'h00;
			b1_reg <= 8'h00;
			b2_reg <= 8'h00;
		end else if (ce_i && wr_instr) begin
			op_reg <= wr_word[7:0];
			b1_reg <= wr_word[15:8];
			b2_reg <= wr_word[23:16];
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			index_pointer_reg <= `CLD_RST_PTR;
		end else if (ce_i && wr_index) begin
			index_pointer_reg <= wr_word[15:0];
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			extra_pointer_reg <= `CLD_RST_PTR;
		end else if (ce_i && wr_extra) begin
			extra_pointer_reg <= wr_word[15:0];
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			for (int i = 0; i < 8; i++) begin
				general_register_i_reg[i] <= `CLD_RST_GREG;
			end
		end else if (ce_i && wr_greg) begin
			general_register_i_reg[avs_address_i[4:2]] <= wr_word[7:0];
		end
	end

	// Data memory has no reset; software loads it before use
	always_ff @(posedge core_clk_i) begin
		if (ce_i && wr_mem) begin
			data_mem[avs_address_i[9:2]] <= wr_word[7:0];
		end
	end

endmodule

// [test/cld_core_monitor.sv]
// Bus and execution timing checker for the decode core
`timescale 1ns/1ps
module cld_core_monitor (
	// Clock, reset, enable
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	// Avalon-MM slave
	input wire logic [11:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	// Status
	input wire logic busy_o
);
	logic [7:0] op_reg;
	logic [2:0] cnt_reg;
	logic [2:0] exp_cyc;
	logic acc_w;
	// Writes while busy are dropped, so only idle writes count
	assign acc_w = avs_write_i && !avs_waitrequest_o && ce_i && avs_byteenable_i[0] && !busy_o;
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			op_reg <= 8'h00;
		end else if (acc_w && avs_address_i == 12'h008) begin
			op_reg <= avs_writedata_i[7:0];
		end
	end
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_reg <= 3'h0;
		end else if (!busy_o) begin
			cnt_reg <= 3'h0;
		end else if (ce_i) begin
			cnt_reg <= cnt_reg + 3'h1;
		end
	end
	always_comb begin
		casez (op_reg)
			8'h74: exp_cyc = 3'h2;
			8'h66, 8'h76: exp_cyc = 3'h4;
			8'hb?: exp_cyc = 3'h5;
			8'h67, 8'h75, 8'h77, 8'hf4, 8'b0110_1???, 8'b0111_1???, 8'b1111_1???: exp_cyc = 3'h3;
			default: exp_cyc = 3'h1;
		endcase
	end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);
	wait_one_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o && ce_i |=> !avs_waitrequest_o)
		else $error("waitrequest did not drop after one cycle");
	wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low for more than one cycle");
	wait_cause_a: assert property (!avs_waitrequest_o |-> $past(avs_read_i || avs_write_i))
		else $error("waitrequest low without a request");
	start_busy_a: assert property (acc_w && avs_address_i == 12'h000 && avs_writedata_i[0] |=> busy_o)
		else $error("start did not raise busy");
	busy_cause_a: assert property ($rose(busy_o) |-> $past(acc_w && avs_address_i == 12'h000 && avs_writedata_i[0]))
		else $error("busy rose without a start");
	busy_len_a: assert property ($fell(busy_o) |-> cnt_reg == exp_cyc)
		else $error("instruction cycle count wrong");
	ctrl_zero_a: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == 12'h000 |-> avs_readdata_o == 32'h0)
		else $error("control register read not zero");
	unmapped_a: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == 12'h020 |-> avs_readdata_o == 32'h0)
		else $error("unmapped read not zero");
	cover property ($fell(busy_o) && exp_cyc == 3'h5);
	cover property ($fell(busy_o) && exp_cyc == 3'h2);
	cover property (busy_o && !ce_i);
	cover property (avs_read_i && !avs_waitrequest_o && avs_address_i == 12'h020);
endmodule

bind cld_core cld_core_monitor mon_u (.core_clk_i, .resetn_i, .ce_i, .avs_address_i, .avs_read_i, .avs_write_i,
	.avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .busy_o);

// [test/cld_core_tb.sv]
// Self-checking bench for the decode core
`timescale 1ns/1ps
module cld_core_tb;
	logic core_clk_i;
	logic resetn_i;
	logic ce_i;
	logic [11:0] avs_address_i;
	logic avs_read_i;
	logic avs_write_i;
	logic [31:0] avs_writedata_i;
	logic [3:0] avs_byteenable_i;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic busy_o;
	int num_errors;
	int comparisons;
	int n;
	logic [31:0] rdat;
	// Address and data of the starting state
	localparam logic [27:0] INIT [0:9] = '{28'h010_0100, 28'h00c_12f3, 28'h014_0003, 28'h01c_0010,
		28'h018_0020, 28'h048_0055, 28'h054_0000, 28'h440_008c, 28'h494_000f, 28'h4c0_0040};
	// Instruction word, cycles, then acc, pc and flags after it
	localparam logic [63:0] TV [0:20] = '{
		64'h000067_3_1280_0101_9,
		64'h000566_4_1200_0103_5,
		64'h008174_2_1281_0105_9,
		64'h00006a_3_1201_0106_1,
		64'h003075_3_1241_0108_1,
		64'h000077_3_12cd_0109_9,
		64'h000576_4_12cf_010b_9,
		64'h00007d_3_12cf_010c_9,
		64'h0010fd_3_12cf_010e_9,
		64'h00f0fc_3_12cf_0100_9,
		64'h0004f9_3_12cf_0106_9,
		64'h0004f8_3_12cf_0108_9,
		64'h007ffb_3_12cf_0189_9,
		64'h0004fa_3_12cf_018b_9,
		64'h0080ff_3_12cf_010d_9,
		64'h0004fe_3_12cf_010f_9,
		64'h0230b3_5_12cf_0114_d,
		64'hfe30be_5_12cf_0115_9,
		64'h0230b6_5_12cf_0118_9,
		64'h0000f4_3_0119_12cf_9,
		64'h000000_1_0119_12cf_9};

	cld_core dut_u (.core_clk_i, .resetn_i, .ce_i, .avs_address_i, .avs_read_i, .avs_write_i,
		.avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .busy_o);

	initial begin
		core_clk_i = 1'b0;
		forever #4 core_clk_i = ~core_clk_i;
	end

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One Avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic rd, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		avs_read_i <= rd;
		avs_write_i <= !rd;
		avs_address_i <= a;
		avs_writedata_i <= d;
		do @(posedge core_clk_i); while (avs_waitrequest_o !== 1'b0);
		rdat = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask

	task automatic finish_test();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		#100000;
		num_errors++;
		finish_test();
	end

	initial begin
		num_errors = 0;
		comparisons = 0;
		resetn_i = 1'b0;
		ce_i = 1'b1;
		avs_address_i = 12'h000;
		avs_read_i = 1'b0;
		avs_write_i = 1'b0;
		avs_writedata_i = 32'h0;
		avs_byteenable_i = 4'hf;
		repeat (2) @(posedge core_clk_i);
		resetn_i <= 1'b1;
		bus(1'b1, 12'h00c, 32'h0);
		chk("acc after reset", rdat, 32'h0);
		foreach (INIT[i]) begin
			bus(1'b0, INIT[i][27:16], {16'h0, INIT[i][15:0]});
		end
		foreach (TV[i]) begin
			bus(1'b0, 12'h008, {8'h00, TV[i][63:40]});
			bus(1'b0, 12'h000, 32'h1);
			n = 0;
			// Enable low must freeze the running instruction
			if (i == 2) begin
				ce_i <= 1'b0;
				repeat (4) @(posedge core_clk_i);
				chk("busy held", {31'h0, busy_o}, 32'h1);
				ce_i <= 1'b1;
			end
			@(posedge core_clk_i);
			while (busy_o === 1'b1) begin
				n++;
				@(posedge core_clk_i);
			end
			chk("cycles", 32'(n), {28'h0, TV[i][39:36]});
			bus(1'b1, 12'h00c, 32'h0);
			chk("acc", rdat, {16'h0, TV[i][35:20]});
			bus(1'b1, 12'h010, 32'h0);
			chk("pc", rdat, {16'h0, TV[i][19:4]});
			bus(1'b1, 12'h014, 32'h0);
			chk("flags", rdat, {28'h0, TV[i][3:0]});
		end
		// Last entry is unsupported: count 1 and illegal set
		bus(1'b1, 12'h004, 32'h0);
		chk("status", rdat & 32'h75, 32'h14);
		// Bit branch taken; an acc write while busy is dropped
		bus(1'b0, 12'h008, 32'h0004_30b0);
		bus(1'b0, 12'h000, 32'h1);
		bus(1'b0, 12'h00c, 32'h5555);
		while (busy_o === 1'b1) @(posedge core_clk_i);
		bus(1'b1, 12'h00c, 32'h0);
		chk("acc kept", rdat, 32'h0119);
		bus(1'b1, 12'h010, 32'h0);
		chk("pc bit branch", rdat, 32'h12d6);
		bus(1'b1, 12'h004, 32'h0);
		chk("status taken", rdat & 32'h77, 32'h52);
		// Only lane 1 of acc is written
		avs_byteenable_i <= 4'h2;
		bus(1'b0, 12'h00c, 32'h0000_ab00);
		avs_byteenable_i <= 4'hf;
		bus(1'b1, 12'h00c, 32'h0);
		chk("acc lane", rdat, 32'hab19);
		// Reset while idle clears the program counter
		resetn_i <= 1'b0;
		@(posedge core_clk_i);
		resetn_i <= 1'b1;
		bus(1'b1, 12'h010, 32'h0);
		chk("pc after reset", rdat, 32'h0);
		bus(1'b1, 12'h020, 32'h0);
		chk("unmapped", rdat, 32'h0);
		bus(1'b1, 12'h000, 32'h0);
		chk("ctrl", rdat, 32'h0);
		finish_test();
	end
endmodule
